// *** ciec_pkg.sv ***
// package: register map, field layout and shared types of the CAN interrupt and error-count block
package ciec_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CIEC_OFS_STAT_EN_SET   = 12'h074;
  localparam logic [11:0] CIEC_OFS_STAT_EN_CLR   = 12'h078;
  localparam logic [11:0] CIEC_OFS_STAT_MASK     = 12'h07C;
  localparam logic [11:0] CIEC_OFS_OBJ_PEND      = 12'h084;
  localparam logic [11:0] CIEC_OFS_OBJ_EN_SET    = 12'h088;
  localparam logic [11:0] CIEC_OFS_OBJ_EN_CLR    = 12'h08C;
  localparam logic [11:0] CIEC_OFS_OBJ_MASK      = 12'h090;
  localparam logic [11:0] CIEC_OFS_TOP_CODE      = 12'h094;
  localparam logic [11:0] CIEC_OFS_ERR_CNT       = 12'h098;
  localparam logic [11:0] CIEC_OFS_XFER0         = 12'h100;
  localparam logic [11:0] CIEC_OFS_XFER1         = 12'h120;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  // writable status-enable bits: 1..4 and 8..15
  localparam logic [31:0] CIEC_STAT_BITS_MASK    = 32'h0000_FF1E;
  localparam int          CIEC_BIT_ACTIVITY      = 4;
  localparam logic [31:0] CIEC_XFER_WR_MASK      = 32'h0000_DFBF;
  localparam logic [31:0] CIEC_XFER_RESET        = 32'h0000_0001;
  localparam logic [31:0] CIEC_ZERO_WORD         = 32'h0000_0000;
  localparam logic [15:0] CIEC_CODE_NONE         = 16'h0000;
  localparam logic [15:0] CIEC_CODE_STATUS       = 16'h8000;
  localparam logic [7:0]  CIEC_WARN_LIMIT        = 8'h60;
  localparam logic [7:0]  CIEC_PASSIVE_LIMIT     = 8'h80;
  localparam int          CIEC_OBJ_COUNT         = 32;
  localparam logic [1:0]  CIEC_RESP_OKAY         = 2'b00;
  localparam logic [1:0]  CIEC_RESP_SLVERR       = 2'b10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] tx_err_count;
    logic [7:0] rx_err_count;
  } ciec_err_type;

  typedef struct packed {
    logic [15:0] status_events;
    logic [31:0] object_irq_pending;
  } ciec_src_type;

endpackage : ciec_pkg

// *** ciec_top.sv ***
// module: interrupt enable/mask/priority bookkeeping and error counter view over AXI4-Lite
`timescale 1ns/100ps

module ciec_top (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_b_i,
  // event sources from the protocol engine and message ram
  input  wire ciec_pkg::ciec_src_type src_i,
  input  wire ciec_pkg::ciec_err_type err_i,
  // axi4-lite write address
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [11:0]          s_axi_awaddr_i,
  // axi4-lite write data
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  // axi4-lite write response
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  output logic [1:0]                s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  input  wire logic [11:0]          s_axi_araddr_i,
  // axi4-lite read data
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  // interrupt request and warning event
  output logic                      irq_o,
  output logic                      passive_warn_transition_o
);
  import ciec_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] stat_en_r;
  logic [31:0] obj_en_r;
  logic [31:0] xfer0_r;
  logic [31:0] xfer1_r;
  logic        aw_held_r;
  logic        w_held_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        warn_level_r;
  logic [15:0] top_irq_code_r;

  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] wr_bits;
  logic        wr_fire;
  logic        wr_hit;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [15:0] top_code_nxt;
  logic        warn_level_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] strb_expand(input logic [3:0] s);
    strb_expand = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_expand

  function automatic logic [15:0] lowest_object(input logic [31:0] v);
    lowest_object = CIEC_CODE_NONE;
    for (int i = CIEC_OBJ_COUNT - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest_object = 16'(i + 1);
      end
    end
  endfunction : lowest_object

  // ----------------------------------------------------------------
  // axi write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held_r && !s_axi_bvalid_o;
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr_i;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata_i;
  assign wr_bits = wr_data & strb_expand(w_held_r ? w_strb_r : s_axi_wstrb_i);
  assign wr_fire = (aw_held_r || (s_axi_awvalid_i && s_axi_awready_o))
                && (w_held_r || (s_axi_wvalid_i && s_axi_wready_o));

  always_comb begin
    case (wr_addr)
      CIEC_OFS_STAT_EN_SET, CIEC_OFS_STAT_EN_CLR,
      CIEC_OFS_OBJ_EN_SET, CIEC_OFS_OBJ_EN_CLR,
      CIEC_OFS_XFER0, CIEC_OFS_XFER1: wr_hit = 1'b1;
      default:                         wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= CIEC_ZERO_WORD;
      w_strb_r  <= 4'h0;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= CIEC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_hit ? CIEC_RESP_OKAY : CIEC_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // enable flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_en_r <= CIEC_ZERO_WORD;
    end else if (wr_fire && wr_addr == CIEC_OFS_STAT_EN_SET) begin
      stat_en_r <= stat_en_r | (wr_bits & CIEC_STAT_BITS_MASK);
    end else if (wr_fire && wr_addr == CIEC_OFS_STAT_EN_CLR) begin
      stat_en_r <= stat_en_r & ~(wr_bits & CIEC_STAT_BITS_MASK);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      obj_en_r <= CIEC_ZERO_WORD;
    end else if (wr_fire && wr_addr == CIEC_OFS_OBJ_EN_SET) begin
      obj_en_r <= obj_en_r | wr_bits;
    end else if (wr_fire && wr_addr == CIEC_OFS_OBJ_EN_CLR) begin
      obj_en_r <= obj_en_r & ~wr_bits;
    end
  end

  // ----------------------------------------------------------------
  // transfer-control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xfer0_r <= CIEC_XFER_RESET;
      xfer1_r <= CIEC_XFER_RESET;
    end else if (wr_fire && wr_addr == CIEC_OFS_XFER0) begin
      xfer0_r <= (xfer0_r & ~strb_expand(w_held_r ? w_strb_r : s_axi_wstrb_i))
               | (wr_bits & CIEC_XFER_WR_MASK);
    end else if (wr_fire && wr_addr == CIEC_OFS_XFER1) begin
      xfer1_r <= (xfer1_r & ~strb_expand(w_held_r ? w_strb_r : s_axi_wstrb_i))
               | (wr_bits & CIEC_XFER_WR_MASK);
    end
  end

  // ----------------------------------------------------------------
  // priority code and interrupt request
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] stat_live;
    stat_live = {16'h0000, src_i.status_events} & stat_en_r & CIEC_STAT_BITS_MASK;
    stat_live[CIEC_BIT_ACTIVITY] = 1'b0;
    if (|stat_live) begin
      top_code_nxt = CIEC_CODE_STATUS;
    end else begin
      // sources stay pending until cleared upstream
      top_code_nxt = lowest_object(src_i.object_irq_pending & obj_en_r);
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      top_irq_code_r <= CIEC_CODE_NONE;
    end else begin
      top_irq_code_r <= top_code_nxt;
    end
  end

  assign irq_o = |top_irq_code_r;

  // ----------------------------------------------------------------
  // warning event: one-cycle pulse on reaching the limit
  // ----------------------------------------------------------------
  assign warn_level_nxt = (err_i.rx_err_count >= CIEC_WARN_LIMIT)
                       || (err_i.tx_err_count >= CIEC_WARN_LIMIT);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      warn_level_r              <= 1'b0;
      passive_warn_transition_o <= 1'b0;
    end else begin
      warn_level_r              <= warn_level_nxt;
      passive_warn_transition_o <= warn_level_nxt && !warn_level_r;
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = CIEC_ZERO_WORD;
    case (s_axi_araddr_i)
      CIEC_OFS_STAT_EN_SET, CIEC_OFS_STAT_EN_CLR,
      CIEC_OFS_OBJ_EN_SET, CIEC_OFS_OBJ_EN_CLR: rd_word = CIEC_ZERO_WORD;
      CIEC_OFS_STAT_MASK: rd_word = stat_en_r;
      CIEC_OFS_OBJ_PEND:  rd_word = src_i.object_irq_pending;
      CIEC_OFS_OBJ_MASK:  rd_word = obj_en_r;
      CIEC_OFS_TOP_CODE:  rd_word = {16'h0000, top_irq_code_r};
      CIEC_OFS_ERR_CNT:   rd_word = {16'h0000, err_i.tx_err_count,
                                     (err_i.rx_err_count >= CIEC_PASSIVE_LIMIT),
                                     err_i.rx_err_count[6:0]};
      CIEC_OFS_XFER0:     rd_word = xfer0_r;
      CIEC_OFS_XFER1:     rd_word = xfer1_r;
      default:            rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= CIEC_ZERO_WORD;
      s_axi_rresp_o  <= CIEC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_word;
      s_axi_rresp_o  <= rd_hit ? CIEC_RESP_OKAY : CIEC_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

endmodule : ciec_top

// *** ciec_top_bench.sv ***
// testbench: self-checking register and priority tests for ciec_top
`timescale 1ns/100ps
module ciec_top_bench;
  import ciec_pkg::*;
  typedef struct packed {
    logic [11:0] wa;
    logic [31:0] wd;
    logic [15:0] st;
    logic [31:0] pd;
    logic [15:0] er;
    logic [11:0] ra;
    logic [31:0] ex;
  } ciec_row_type;
  logic         mclk_i = 1'b0;
  logic         rst_b_i = 1'b0;
  logic         awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic         awr, wrd, bv, arr, rv, irq, warn;
  logic [11:0]  awa = 12'h000, ara = 12'h000;
  logic [31:0]  wd = 32'h0000_0000, rd, got;
  logic [1:0]   br, rr, rsp;
  ciec_src_type src = '0;
  ciec_err_type err = '0;
  int           error_cnt = 0, cmp_count = 0, n;
  // write addr 0 means read only
  ciec_row_type rows [13] = '{
    '{12'h074, 32'hFFFF_FFFF, 16'h0000, 32'h0000_0000, 16'h0000, 12'h07C, 32'h0000_FF1E},
    '{12'h078, 32'h0000_0202, 16'h0000, 32'h0000_0000, 16'h0000, 12'h07C, 32'h0000_FD1C},
    '{12'h088, 32'h8000_0001, 16'h0000, 32'h0000_0000, 16'h0000, 12'h090, 32'h8000_0001},
    '{12'h088, 32'h0000_0100, 16'h0000, 32'h0000_0000, 16'h0000, 12'h090, 32'h8000_0101},
    '{12'h08C, 32'h0000_0001, 16'h0000, 32'h8000_0101, 16'h0000, 12'h084, 32'h8000_0101},
    '{12'h000, 32'h0000_0000, 16'h0012, 32'h8000_0101, 16'h0000, 12'h094, 32'h0000_0009},
    '{12'h000, 32'h0000_0000, 16'h0412, 32'h8000_0101, 16'h0000, 12'h094, 32'h0000_8000},
    '{12'h000, 32'h0000_0000, 16'h0000, 32'h8000_0001, 16'h0000, 12'h094, 32'h0000_0020},
    '{12'h000, 32'h0000_0000, 16'h0000, 32'h0000_0000, 16'h3C85, 12'h098, 32'h0000_3C85},
    '{12'h000, 32'h0000_0000, 16'h0000, 32'h0000_0000, 16'hFF7F, 12'h098, 32'h0000_FF7F},
    '{12'h000, 32'h0000_0000, 16'h0000, 32'h0000_0000, 16'h0000, 12'h094, 32'h0000_0000},
    '{12'h100, 32'hFFFF_FFFF, 16'h0000, 32'h0000_0000, 16'h0000, 12'h100, 32'h0000_DFBF},
    '{12'h000, 32'h0000_0000, 16'h0000, 32'h0000_0000, 16'h0000, 12'h088, 32'h0000_0000}
  };

  ciec_top dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .src_i(src), .err_i(err),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_bresp_o(br),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
    .irq_o(irq), .passive_warn_transition_o(warn)
  );

  always #5 mclk_i = ~mclk_i;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // ready is looked at mid-cycle, so it is what the next rising edge samples
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, da, dw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge mclk_i);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    bry <= 1'b1;
    while (!(da && dw)) begin
      @(negedge mclk_i);
      ta = !da && awr;
      tw = !dw && wrd;
      @(posedge mclk_i);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      da = da || ta;
      dw = dw || tw;
    end
    do @(negedge mclk_i); while (bv !== 1'b1);
    r = br;
    @(posedge mclk_i);
    bry <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do @(negedge mclk_i); while (arr !== 1'b1);
    @(posedge mclk_i);
    arv <= 1'b0;
    do @(negedge mclk_i); while (rv !== 1'b1);
    d = rd;
    r = rr;
    @(posedge mclk_i);
    rry <= 1'b0;
  endtask : axi_rd

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // table, then refusals, persistence, warning edge and reset
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    foreach (rows[i]) begin
      @(posedge mclk_i);
      src <= {rows[i].st, rows[i].pd};
      err <= rows[i].er;
      if (rows[i].wa != 12'h000) begin
        axi_wr(rows[i].wa, rows[i].wd, rsp);
        chk({30'h0, rsp}, {30'h0, CIEC_RESP_OKAY});
      end
      repeat (2) @(posedge mclk_i);
      axi_rd(rows[i].ra, got, rsp);
      chk(got, rows[i].ex);
      chk({30'h0, rsp}, {30'h0, CIEC_RESP_OKAY});
      if (rows[i].ra == CIEC_OFS_TOP_CODE)
        chk({31'h0, irq}, {31'h0, rows[i].ex != 32'h0000_0000});
    end
    axi_wr(CIEC_OFS_STAT_MASK, 32'hFFFF_FFFF, rsp);
    chk({30'h0, rsp}, {30'h0, CIEC_RESP_SLVERR});
    axi_rd(CIEC_OFS_STAT_MASK, got, rsp);
    chk(got, 32'h0000_FD1C);
    axi_wr(12'h0A0, 32'hFFFF_FFFF, rsp);
    chk({30'h0, rsp}, {30'h0, CIEC_RESP_SLVERR});
    axi_rd(12'h0A0, got, rsp);
    chk({got[29:0], rsp}, {30'h0, CIEC_RESP_SLVERR});
    axi_wr(CIEC_OFS_OBJ_EN_SET, 32'h0000_0004, rsp);
    src <= {16'h0000, 32'h0000_0004};
    repeat (20) @(posedge mclk_i);
    axi_rd(CIEC_OFS_TOP_CODE, got, rsp);
    chk(got, 32'h0000_0003);
    src <= '0;
    repeat (2) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      err <= k ? {8'h5F, 8'h00} : {8'h00, 8'h5F};
      repeat (3) @(posedge mclk_i);
      err <= k ? {8'h60, 8'h00} : {8'h00, 8'h60};
      n = 0;
      repeat (6) begin
        @(negedge mclk_i);
        n += (warn === 1'b1);
      end
      chk(32'(n), 32'h0000_0001);
    end
    @(posedge mclk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    axi_rd(CIEC_OFS_STAT_MASK, got, rsp);
    chk(got, 32'h0000_0000);
    axi_rd(CIEC_OFS_OBJ_MASK, got, rsp);
    chk(got, 32'h0000_0000);
    axi_rd(CIEC_OFS_XFER0, got, rsp);
    chk(got, 32'h0000_0001);
    axi_rd(CIEC_OFS_XFER1, got, rsp);
    chk(got, 32'h0000_0001);
    stop_test();
  end
endmodule : ciec_top_bench

// *** ciec_top_chk.sv ***
// checker: concurrent assertions on the ports of ciec_top
`timescale 1ns/100ps
module ciec_top_chk
  import ciec_pkg::*;
(
  // clock, reset and sources
  input wire logic                   mclk_i,
  input wire logic                   rst_b_i,
  input wire ciec_pkg::ciec_src_type src_i,
  input wire ciec_pkg::ciec_err_type err_i,
  // read channel
  input wire logic                   s_axi_arvalid_i,
  input wire logic                   s_axi_arready_o,
  input wire logic [11:0]            s_axi_araddr_i,
  input wire logic [31:0]            s_axi_rdata_o,
  // request and warning
  input wire logic                   irq_o,
  input wire logic                   passive_warn_transition_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic rd_go;
  logic warn_lvl;
  assign rd_go = s_axi_arvalid_i && s_axi_arready_o;
  assign warn_lvl = (err_i.rx_err_count >= CIEC_WARN_LIMIT) ||
                    (err_i.tx_err_count >= CIEC_WARN_LIMIT);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pend_view: assert property (rd_go && s_axi_araddr_i == CIEC_OFS_OBJ_PEND
    |=> s_axi_rdata_o == $past(src_i.object_irq_pending))
    else $error("pending view differs from sources");
  a_err_view: assert property (rd_go && s_axi_araddr_i == CIEC_OFS_ERR_CNT
    |=> s_axi_rdata_o == {16'h0000, $past(err_i)})
    else $error("error counter view wrong");
  a_code_range: assert property (rd_go && s_axi_araddr_i == CIEC_OFS_TOP_CODE
    |=> s_axi_rdata_o <= 32'h0000_0020 || s_axi_rdata_o == 32'h0000_8000)
    else $error("priority code in reserved range");
  a_code_irq: assert property (rd_go && s_axi_araddr_i == CIEC_OFS_TOP_CODE
    |=> (s_axi_rdata_o != 32'h0000_0000) == $past(irq_o))
    else $error("irq disagrees with priority code");
  a_irq_idle: assert property (src_i == '0 |=> !irq_o)
    else $error("irq high with no source");
  a_warn_rise: assert property (!warn_lvl ##1 warn_lvl |=> passive_warn_transition_o)
    else $error("warning pulse missing");
  a_warn_single: assert property (passive_warn_transition_o |=> !passive_warn_transition_o)
    else $error("warning pulse too long");
  a_warn_cause: assert property (passive_warn_transition_o |-> $past(warn_lvl))
    else $error("warning pulse without cause");
endmodule : ciec_top_chk

bind ciec_top ciec_top_chk u_chk (
  .mclk_i, .rst_b_i, .src_i, .err_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_araddr_i, .s_axi_rdata_o, .irq_o, .passive_warn_transition_o
);
